// ===== hw/kif_keypad_input_filter.sv
// Keypad input filter: polarity select, optional three-sample filter, key capture.
// Assumes a single system clock and a shared prescaler value driven by the unit.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module kif_keypad_input_filter #(
    parameter int KEYS = 5,
    parameter int PRESCALE_W = 12
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [PRESCALE_W-1:0] prescale_value,
    input wire logic [KEYS-1:0] key_in,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic [KEYS-1:0] key_filtered,
    output logic key_event,
    output logic scan_restart
);
    logic [15:0] filter_div_reg;
    logic [15:0] control_reg;
    logic [KEYS-1:0] sync1_reg, sync2_reg, sync3_reg, stable_reg;
    logic [PRESCALE_W-1:0] pre_cnt_reg;
    logic [15:0] div_cnt_reg;
    logic tick_reg;
    logic [KEYS-1:0] cand_reg;
    logic [1:0] same_cnt_reg;
    logic [KEYS-1:0] filt_reg;
    logic [KEYS-1:0] capture_reg;
    logic captured_reg;
    logic [KEYS-1:0] polar_in;
    logic [KEYS-1:0] key_value;
    logic filter_on;
    logic restart_hit;
    logic [KEYS-1:0] polarity;

    // Address decode shared by the write and restart paths; the read path decodes with a case
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
        return addr == target;
    endfunction

    assign filter_on = control_reg[kif_pkg::FILTER_EN_BIT];
    assign polarity = control_reg[KEYS-1:0];
    // Only a 1 in the restart bit acts; writing 0 there is harmless
    assign restart_hit = reg_write && addr_hit(reg_addr, kif_pkg::ADDR_RESTART) && reg_wdata[kif_pkg::RESTART_BIT];

    // Register writes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filter_div_reg <= kif_pkg::FILTER_DIV_RESET;
            control_reg <= kif_pkg::CONTROL_RESET;
        end else if (reg_write) begin
            if (addr_hit(reg_addr, kif_pkg::ADDR_FILTER_DIV)) begin
                filter_div_reg <= reg_wdata;
            end
            // Bits between the enable and the polarity field are not stored and read 0
            if (addr_hit(reg_addr, kif_pkg::ADDR_CONTROL)) begin
                control_reg <= (16'(reg_wdata[kif_pkg::FILTER_EN_BIT]) << kif_pkg::FILTER_EN_BIT) | 16'(reg_wdata[KEYS-1:0]);
            end
        end
    end

    // Pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            stable_reg <= '0;
        end else begin
            sync1_reg <= key_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < KEYS; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    stable_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // Polarity select per key
    assign polar_in = stable_reg ^ polarity;

    // Two-stage divider; held idle while the filter is off to save toggling
    always_ff @(posedge clk) begin
        if (!rst_n || !filter_on) begin
            pre_cnt_reg <= '0;
            div_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= 1'b0;
            if (pre_cnt_reg >= prescale_value) begin
                pre_cnt_reg <= '0;
                if (div_cnt_reg >= filter_div_reg) begin
                    div_cnt_reg <= '0;
                    tick_reg <= 1'b1;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 16'h0001;
                end
            end else begin
                pre_cnt_reg <= pre_cnt_reg + PRESCALE_W'(1);
            end
        end
    end

    // Three consecutive equal samples move the filtered value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cand_reg <= '0;
            same_cnt_reg <= 2'h0;
            filt_reg <= '0;
        end else if (!filter_on) begin
            filt_reg <= polar_in; // Keeps the filter primed for a later enable
            cand_reg <= polar_in;
            same_cnt_reg <= 2'h0;
        end else if (tick_reg) begin
            if (polar_in == filt_reg) begin
                same_cnt_reg <= 2'h0;
            end else if (polar_in != cand_reg || same_cnt_reg == 2'h0) begin
                cand_reg <= polar_in;
                same_cnt_reg <= 2'h1;
            end else if (same_cnt_reg == 2'(kif_pkg::FILTER_SAMPLES - 1)) begin
                filt_reg <= polar_in;
                same_cnt_reg <= 2'h0;
            end else begin
                same_cnt_reg <= same_cnt_reg + 2'h1;
            end
        end
    end

    // Bypass or filtered path
    assign key_value = filter_on ? filt_reg : polar_in;

    // Capture first key activity; restart releases the capture
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            capture_reg <= '0;
            captured_reg <= 1'b0;
            key_filtered <= '0;
            key_event <= 1'b0;
            scan_restart <= 1'b0;
        end else begin
            key_filtered <= key_value;
            scan_restart <= restart_hit;
            key_event <= 1'b0;
            if (!captured_reg && key_value != '0) begin // Set wins over restart
                capture_reg <= key_value;
                captured_reg <= 1'b1;
                key_event <= 1'b1;
            end else if (restart_hit) begin
                capture_reg <= '0;
                captured_reg <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                kif_pkg::ADDR_FILTER_DIV: reg_rdata <= filter_div_reg;
                kif_pkg::ADDR_CONTROL: reg_rdata <= control_reg;
                kif_pkg::ADDR_KEY_DATA: reg_rdata <= (16'(capture_reg) << kif_pkg::KEY_DATA_LSB) | 16'(capture_reg);
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // Checker helper: the tick period as the rule gives it
    logic [28:0] tick_period;
    logic [28:0] period_reg;
    logic [28:0] gap_reg;
    logic gap_valid_reg;

    assign tick_period = 29'((29'(prescale_value) + 29'h0000001) * (29'(filter_div_reg) + 29'h0000001));

    // Last clock's period, so that a change of either divider can be seen
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            period_reg <= 29'h0000000;
        end else begin
            period_reg <= tick_period;
        end
    end

    // Clocks since the last tick; a period change leaves the counters mid-way, so the gap is not trusted then
    always_ff @(posedge clk) begin
        if (!rst_n || !filter_on || period_reg != tick_period) begin
            gap_reg <= 29'h0000000;
            gap_valid_reg <= 1'b0;
        end else if (tick_reg) begin
            gap_reg <= 29'h0000001;
            gap_valid_reg <= 1'b1;
        end else begin
            gap_reg <= gap_reg + 29'h0000001;
        end
    end

    // Bypass follows the polarity stage one clock later
    a_bypass_path: assert property (@(posedge clk) disable iff (!rst_n)
        !filter_on |=> key_filtered == $past(polar_in)) else $error("bypass path wrong");
    // While the filter stays on, the filtered value only moves on a tick
    a_filter_hold: assert property (@(posedge clk) disable iff (!rst_n)
        filter_on && $past(filter_on) && !$past(tick_reg) |-> filt_reg == $past(filt_reg))
        else $error("filter moved without tick");
    // A move needs the earlier equal samples already counted
    a_filter_step: assert property (@(posedge clk) disable iff (!rst_n)
        filter_on && $past(filter_on) && filt_reg != $past(filt_reg)
        |-> $past(tick_reg) && $past(same_cnt_reg) == 2'(kif_pkg::FILTER_SAMPLES - 1))
        else $error("filter moved too early");
    a_no_tick_off: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(filter_on) |-> !tick_reg) else $error("tick while disabled");
    // Ticks under a steady setting are exactly one period apart
    a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        tick_reg && gap_valid_reg |-> gap_reg == tick_period) else $error("tick spacing wrong");
    a_restart_clear: assert property (@(posedge clk) disable iff (!rst_n)
        restart_hit && captured_reg |=> !captured_reg || key_event) else $error("restart ignored");
    a_restart_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        restart_hit |=> scan_restart) else $error("restart pulse missing");
    a_event_capture: assert property (@(posedge clk) disable iff (!rst_n)
        key_event |-> captured_reg && capture_reg == $past(key_value)) else $error("capture wrong");
    // Checked at the output, so a wrong polarity stage is caught too
    a_polarity_map: assert property (@(posedge clk) disable iff (!rst_n)
        !filter_on |=> (key_filtered ^ $past(stable_reg)) == $past(polarity)) else $error("polarity wrong");
    // An in-range count stays in range while the divider is left alone
    a_div_bound: assert property (@(posedge clk) disable iff (!rst_n)
        filter_on && $past(filter_on) && $stable(filter_div_reg) && $past(div_cnt_reg) <= $past(filter_div_reg)
        |-> div_cnt_reg <= filter_div_reg) else $error("divider overran");
    // Read data stand only in the cycle after a read strobe
    a_read_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(reg_read) |-> reg_rdata == 16'h0000) else $error("read data outside its cycle");
endmodule
`default_nettype wire

// ===== hw/kif_pkg.sv
// Package for the keypad input filter: register offsets, fields, reset values.
// Assumes a 16-bit register port with word offsets as printed.
package kif_pkg;
    localparam logic [15:0] ADDR_FILTER_DIV = 16'h5006;
    localparam logic [15:0] ADDR_CONTROL = 16'h5008;
    localparam logic [15:0] ADDR_KEY_DATA = 16'h5004;
    localparam logic [15:0] ADDR_RESTART = 16'h500E;
    localparam int FILTER_EN_BIT = 15;
    localparam int RESTART_BIT = 0;
    localparam int KEY_DATA_LSB = 8;
    localparam logic [15:0] FILTER_DIV_RESET = 16'h0000;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam int SYNC_STAGES = 3;
    localparam int FILTER_SAMPLES = 3;
endpackage

// ===== testbench/kif_keypad_input_filter_tb.sv
// Testbench for the keypad input filter.
// Assumes the design package and the keypad model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module kif_keypad_input_filter_tb;
    logic clk, rst_n, reg_write, reg_read, key_event, scan_restart, rd_q;
    logic [11:0] prescale_value;
    logic [4:0] pressed, key_in, key_filtered, k, p;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [15:0] exp_q[$];
    int num_errors = 0, n_checks = 0, ev_n = 0, rs_n = 0;
    kif_keypad_input_filter DUT (.clk(clk), .rst_n(rst_n), .prescale_value(prescale_value), .key_in(key_in),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .key_filtered(key_filtered), .key_event(key_event), .scan_restart(scan_restart));
    kif_keypad_model keypad (.clk(clk), .pressed(pressed), .key_in(key_in));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_q <= reg_read;
        if (rd_q === 1'b1) chk(reg_rdata, exp_q.pop_front());
        if (key_event === 1'b1) ev_n++;
        if (scan_restart === 1'b1) rs_n++;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
    endtask
    // Bounded wait; running out counts a mismatch and ends the run
    task automatic expect_keys(input logic [4:0] e, input int n);
        for (int i = 0; i < n && key_filtered !== e; i++) @(posedge clk);
        chk({11'h0, key_filtered}, {11'h0, e});
        if (key_filtered !== e) end_of_test();
    endtask
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h77601d39));
        {rst_n, reg_write, reg_read, reg_addr, reg_wdata, pressed} = '0;
        prescale_value = 12'h001;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(kif_pkg::ADDR_CONTROL, kif_pkg::CONTROL_RESET);
        rd(kif_pkg::ADDR_FILTER_DIV, kif_pkg::FILTER_DIV_RESET);
        rd(16'h5010, 16'h0000);
        // First press is held until a restart, later ones are ignored
        pressed <= 5'h0A;
        expect_keys(5'h0A, 12);
        pressed <= 5'h11;
        repeat (10) @(posedge clk);
        rd(kif_pkg::ADDR_KEY_DATA, 16'h0A0A);
        pressed <= 5'h00;
        expect_keys(5'h00, 12);
        wr(kif_pkg::ADDR_RESTART, 16'h0001);
        @(posedge clk);
        chk(16'(rs_n), 16'h0001);
        chk(16'(ev_n), 16'h0001);
        rd(kif_pkg::ADDR_KEY_DATA, 16'h0000);
        wr(kif_pkg::ADDR_CONTROL, 16'hFFFF);
        rd(kif_pkg::ADDR_CONTROL, 16'h801F);
        repeat (6) begin
            p = 5'($urandom);
            k = 5'($urandom);
            wr(kif_pkg::ADDR_CONTROL, {11'h0, p});
            pressed <= k;
            expect_keys(k ^ p, 12);
        end
        pressed <= 5'h00;
        wr(kif_pkg::ADDR_CONTROL, 16'h0000);
        expect_keys(5'h00, 12);
        // Tick every 6 clocks, far faster than any scan drive rate
        wr(kif_pkg::ADDR_FILTER_DIV, 16'h0002);
        wr(kif_pkg::ADDR_CONTROL, 16'h8000);
        pressed <= 5'h15;
        repeat (14) @(posedge clk);
        chk({11'h0, key_filtered}, 16'h0000);
        expect_keys(5'h15, 40);
        // A 7-cycle glitch spans at most two ticks
        pressed <= 5'h00;
        repeat (7) @(posedge clk);
        pressed <= 5'h15;
        repeat (30) @(posedge clk);
        chk({11'h0, key_filtered}, 16'h0015);
        // A reset in mid-run clears the outputs and every written register
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk({11'h0, key_filtered}, 16'h0000);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(kif_pkg::ADDR_CONTROL, kif_pkg::CONTROL_RESET);
        rd(kif_pkg::ADDR_FILTER_DIV, kif_pkg::FILTER_DIV_RESET);
        @(posedge clk);
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== testbench/kif_keypad_model.sv
// Keypad switch model driving the key pins.
// Assumes the bench sets the pressed pattern on a clock edge.
`timescale 1ns/100ps
`default_nettype none
module kif_keypad_model (
    input wire logic clk,
    input wire logic [4:0] pressed,
    output logic [4:0] key_in
);
    // Contacts settle one cycle after the press, never instantly
    always @(posedge clk) begin
        key_in <= pressed;
    end
endmodule
`default_nettype wire
